// [vdim_mask.sv]
`timescale 1ns/1ps
`include "vdim_defines.svh"

module vdim_mask (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Subaddress register port
  input  wire logic [7:0] SUB_ADDR,
  input  wire logic       WR_STB,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       RD_STB,
  output logic      [7:0] RD_DATA,
  // Status flags from the decoder core
  input  wire logic [7:0] FLAGS_60,
  input  wire logic [7:0] FLAGS_8F,
  input  wire logic [7:0] FLAGS_1E,
  input  wire logic [7:0] FLAGS_1F,
  // Interrupt request
  output logic            IRQ
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  vdim_pkg::vdim_top_s st_reg;
  vdim_pkg::vdim_top_s st_next;

  logic [3:0][7:0] grp_flags;
  logic [3:0][7:0] grp_enable;
  logic [3:0][7:0] grp_pending;
  logic [3:0][7:0] grp_addr;
  logic [3:0]      grp_clear;
  logic [3:0]      grp_irq;

  // -------------------------------------------------------------------
  // Flag groups and their enables
  // -------------------------------------------------------------------
  assign grp_flags[0] = FLAGS_60;
  assign grp_flags[1] = FLAGS_8F;
  assign grp_flags[2] = FLAGS_1E;
  assign grp_flags[3] = FLAGS_1F;

  assign grp_addr[0] = `VDIM_ADDR_FLAGS_60;
  assign grp_addr[1] = `VDIM_ADDR_FLAGS_8F;
  assign grp_addr[2] = `VDIM_ADDR_FLAGS_1E;
  assign grp_addr[3] = `VDIM_ADDR_FLAGS_1F;

  // Mask one bits 4:2 line up with flag bits 4:2 of group 60
  assign grp_enable[0] = {3'h0,
    st_reg.mask_one[`VDIM_PROGRAM_SERVICE_SIGNAL_IRQ_EN_BIT],
    st_reg.mask_one[`VDIM_WIDESCREEN_PAL_IRQ_EN_BIT],
    st_reg.mask_one[`VDIM_CAPTION_DETECT_IRQ_EN_BIT],
    2'h0};
  // Mask one bit 0 steers flag bit 2 of group 8F
  assign grp_enable[1] = {5'h0,
    st_reg.mask_one[`VDIM_FORMATTER_ERROR_IRQ_EN_BIT],
    2'h0};
  // Masks two and three share bit positions with their flags
  assign grp_enable[2] = st_reg.mask_two;
  assign grp_enable[3] = st_reg.mask_three;

  // -------------------------------------------------------------------
  // Per group change watchers
  // -------------------------------------------------------------------
  // Reading a flag subaddress acknowledges that group's pending events,
  // so the host services by reading the flags it was told about.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_grp
      assign grp_clear[g] = RD_STB && (SUB_ADDR == grp_addr[g]);
      assign grp_irq[g]   = |(grp_pending[g] & grp_enable[g]);
      vdim_watch vdim_watch_inst (
        .clk     (CLK),
        .sys_rst (SYS_RST),
        .flags   (grp_flags[g]),
        .enable  (grp_enable[g]),
        .clear   (grp_clear[g]),
        .pending (grp_pending[g])
      );
    end
  endgenerate

  assign IRQ     = |grp_irq;
  assign RD_DATA = st_reg.rd_data;

  // -------------------------------------------------------------------
  // Register writes and reads
  // -------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (WR_STB) begin
      unique case (SUB_ADDR)
        `VDIM_ADDR_MASK_ONE:
          st_next.mask_one = WR_DATA & `VDIM_VALID_MASK_ONE;
        `VDIM_ADDR_MASK_TWO:
          st_next.mask_two = WR_DATA & `VDIM_VALID_MASK_TWO;
        `VDIM_ADDR_MASK_THREE:
          st_next.mask_three = WR_DATA & `VDIM_VALID_MASK_THREE;
        default: begin
        end
      endcase
    end
    // Other subaddresses belong to other blocks and read zero here
    if (RD_STB) begin
      unique case (SUB_ADDR)
        `VDIM_ADDR_MASK_ONE:   st_next.rd_data = st_reg.mask_one;
        `VDIM_ADDR_MASK_TWO:   st_next.rd_data = st_reg.mask_two;
        `VDIM_ADDR_MASK_THREE: st_next.rd_data = st_reg.mask_three;
        default:               st_next.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg.mask_one   <= `VDIM_RESET_MASK;
      st_reg.mask_two   <= `VDIM_RESET_MASK;
      st_reg.mask_three <= `VDIM_RESET_MASK;
      st_reg.rd_data    <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  vps_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_60[4]) &&
     st_reg.mask_one[`VDIM_PROGRAM_SERVICE_SIGNAL_IRQ_EN_BIT]) |=> IRQ)
    else $error("service signal change did not raise IRQ");

  wide_pal_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_60[3]) &&
     st_reg.mask_one[`VDIM_WIDESCREEN_PAL_IRQ_EN_BIT]) |=> IRQ)
    else $error("widescreen change did not raise IRQ");

  caption_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_60[2]) &&
     st_reg.mask_one[`VDIM_CAPTION_DETECT_IRQ_EN_BIT]) |=> IRQ)
    else $error("caption change did not raise IRQ");

  formatter_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB &&
     $changed(FLAGS_8F[`VDIM_FORMATTER_ERROR_FLAG_BIT]) &&
     st_reg.mask_one[`VDIM_FORMATTER_ERROR_IRQ_EN_BIT]) |=> IRQ)
    else $error("formatter error change did not raise IRQ");

  hpll_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1E[6]) &&
     st_reg.mask_two[`VDIM_HPLL_LOCK_IRQ_EN_BIT]) |=> IRQ)
    else $error("PLL lock change did not raise IRQ");

  std_hi_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1E[1]) &&
     st_reg.mask_two[`VDIM_COLOUR_STD_CHANGE_HI_IRQ_EN_BIT]) |=> IRQ)
    else $error("standard change one did not raise IRQ");

  std_lo_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1E[0]) &&
     st_reg.mask_two[`VDIM_COLOUR_STD_CHANGE_LO_IRQ_EN_BIT])
    |=> IRQ until_with (RD_STB || WR_STB))
    else $error("standard change zero IRQ dropped early");

  interlace_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[7]) &&
     st_reg.mask_three[`VDIM_INTERLACE_CHANGE_IRQ_EN_BIT]) |=> IRQ)
    else $error("interlace change did not raise IRQ");

  hv_lock_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[6]) &&
     st_reg.mask_three[`VDIM_HV_LOCK_IRQ_EN_BIT]) |=> IRQ)
    else $error("combined lock change did not raise IRQ");

  field_rate_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[5]) &&
     st_reg.mask_three[`VDIM_FIELD_RATE_CHANGE_IRQ_EN_BIT]) |=> IRQ)
    else $error("field rate change did not raise IRQ");

  stripe_t3_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[3]) &&
     st_reg.mask_three[`VDIM_STRIPE_BURST_T3_IRQ_EN_BIT]) |=> IRQ)
    else $error("type 3 stripe change did not raise IRQ");

  stripe_any_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[2]) &&
     st_reg.mask_three[`VDIM_STRIPE_BURST_ANY_IRQ_EN_BIT]) |=> IRQ)
    else $error("stripe change did not raise IRQ");

  copy_prot_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[1]) &&
     st_reg.mask_three[`VDIM_COPY_PROTECT_IRQ_EN_BIT]) |=> IRQ)
    else $error("copy protection change did not raise IRQ");

  capture_gate_a: assert property (
    (!$past(SYS_RST) && !WR_STB && $changed(FLAGS_1F[0]) &&
     st_reg.mask_three[`VDIM_CAPTURE_READY_IRQ_EN_BIT]) |=> IRQ)
    else $error("capture ready change did not raise IRQ");

  masked_quiet_a: assert property (
    (st_reg.mask_one == 8'h00 && st_reg.mask_two == 8'h00 &&
     st_reg.mask_three == 8'h00) |-> !IRQ)
    else $error("IRQ raised with every mask bit clear");

  no_event_quiet_a: assert property (
    (!IRQ && $stable(FLAGS_60) && $stable(FLAGS_8F) &&
     $stable(FLAGS_1E) && $stable(FLAGS_1F) && !WR_STB) |=> !IRQ)
    else $error("IRQ raised without a flag change");

  reserved_zero_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_ONE)
    ##1 (RD_STB && SUB_ADDR == `VDIM_ADDR_MASK_ONE && !WR_STB)
    |=> (RD_DATA == ($past(WR_DATA, 2) & `VDIM_VALID_MASK_ONE)))
    else $error("mask one readback not the written value");

  reserved_two_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_MASK_TWO)
    |=> ((RD_DATA & ~`VDIM_VALID_MASK_TWO) == 8'h00))
    else $error("mask two reserved bits read nonzero");

  reserved_three_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_MASK_THREE)
    |=> ((RD_DATA & ~`VDIM_VALID_MASK_THREE) == 8'h00))
    else $error("mask three reserved bit reads nonzero");

  reset_masks_a: assert property (
    $past(SYS_RST) |-> (st_reg.mask_one == 8'h00 &&
      st_reg.mask_two == 8'h00 && st_reg.mask_three == 8'h00 && !IRQ))
    else $error("masks not clear after reset");

  // -------------------------------------------------------------------
  // Checks on clearing, showing hidden events, foreign subaddresses and mask two and three writes
  // -------------------------------------------------------------------
  clear_60_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_FLAGS_60 && $stable(FLAGS_60))
    |=> (grp_pending[0] == 8'h00))
    else $error("flag group 60 not cleared by its read");

  clear_8f_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_FLAGS_8F && $stable(FLAGS_8F))
    |=> (grp_pending[1] == 8'h00))
    else $error("flag group 8F not cleared by its read");

  clear_1e_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_FLAGS_1E && $stable(FLAGS_1E))
    |=> (grp_pending[2] == 8'h00))
    else $error("flag group 1E not cleared by its read");

  clear_1f_a: assert property (
    (RD_STB && SUB_ADDR == `VDIM_ADDR_FLAGS_1F && $stable(FLAGS_1F))
    |=> (grp_pending[3] == 8'h00))
    else $error("flag group 1F not cleared by its read");

  // A hidden event must come back once its mask bit is set again
  show_one_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_ONE &&
     ((|(grp_pending[0] & WR_DATA)) ||
      (grp_pending[1][`VDIM_FORMATTER_ERROR_FLAG_BIT] &&
       WR_DATA[`VDIM_FORMATTER_ERROR_IRQ_EN_BIT]))) |=> IRQ)
    else $error("kept event not shown by mask one");

  show_two_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_TWO &&
     (|(grp_pending[2] & WR_DATA))) |=> IRQ)
    else $error("kept event not shown by mask two");

  show_three_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_THREE &&
     (|(grp_pending[3] & WR_DATA))) |=> IRQ)
    else $error("kept event not shown by mask three");

  foreign_write_a: assert property (
    (WR_STB && SUB_ADDR != `VDIM_ADDR_MASK_ONE &&
     SUB_ADDR != `VDIM_ADDR_MASK_TWO &&
     SUB_ADDR != `VDIM_ADDR_MASK_THREE)
    |=> ($stable(st_reg.mask_one) && $stable(st_reg.mask_two) &&
         $stable(st_reg.mask_three)))
    else $error("write to another subaddress changed a mask");

  foreign_read_a: assert property (
    (RD_STB && SUB_ADDR != `VDIM_ADDR_MASK_ONE &&
     SUB_ADDR != `VDIM_ADDR_MASK_TWO &&
     SUB_ADDR != `VDIM_ADDR_MASK_THREE) |=> (RD_DATA == 8'h00))
    else $error("read of another subaddress not zero");

  mask_two_lands_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_TWO)
    |=> (st_reg.mask_two == ($past(WR_DATA) & `VDIM_VALID_MASK_TWO)))
    else $error("mask two write did not land");

  mask_three_lands_a: assert property (
    (WR_STB && SUB_ADDR == `VDIM_ADDR_MASK_THREE)
    |=> (st_reg.mask_three == ($past(WR_DATA) & `VDIM_VALID_MASK_THREE)))
    else $error("mask three write did not land");

endmodule

// [vdim_defines.svh]
`ifndef VDIM_DEFINES_SVH
`define VDIM_DEFINES_SVH

// ---------------------------------------------------------------------
// Mask register subaddresses
// ---------------------------------------------------------------------
`define VDIM_ADDR_MASK_ONE    8'h2D
`define VDIM_ADDR_MASK_TWO    8'h2E
`define VDIM_ADDR_MASK_THREE  8'h2F

// ---------------------------------------------------------------------
// Status flag subaddresses (flags live elsewhere)
// ---------------------------------------------------------------------
`define VDIM_ADDR_FLAGS_60    8'h60
`define VDIM_ADDR_FLAGS_8F    8'h8F
`define VDIM_ADDR_FLAGS_1E    8'h1E
`define VDIM_ADDR_FLAGS_1F    8'h1F

// ---------------------------------------------------------------------
// Implemented bits and reset values
// ---------------------------------------------------------------------
`define VDIM_VALID_MASK_ONE   8'h1D
`define VDIM_VALID_MASK_TWO   8'h43
`define VDIM_VALID_MASK_THREE 8'hEF
`define VDIM_RESET_MASK       8'h00
`define VDIM_RESET_FLAGS      8'h00

// ---------------------------------------------------------------------
// Field positions, first mask register
// ---------------------------------------------------------------------
`define VDIM_PROGRAM_SERVICE_SIGNAL_IRQ_EN_BIT 4
`define VDIM_WIDESCREEN_PAL_IRQ_EN_BIT         3
`define VDIM_CAPTION_DETECT_IRQ_EN_BIT         2
`define VDIM_FORMATTER_ERROR_IRQ_EN_BIT        0
// Status bit of the formatter error flag in its own register
`define VDIM_FORMATTER_ERROR_FLAG_BIT          2

// ---------------------------------------------------------------------
// Field positions, second mask register
// ---------------------------------------------------------------------
`define VDIM_HPLL_LOCK_IRQ_EN_BIT              6
`define VDIM_COLOUR_STD_CHANGE_HI_IRQ_EN_BIT   1
`define VDIM_COLOUR_STD_CHANGE_LO_IRQ_EN_BIT   0

// ---------------------------------------------------------------------
// Field positions, third mask register
// ---------------------------------------------------------------------
`define VDIM_INTERLACE_CHANGE_IRQ_EN_BIT       7
`define VDIM_HV_LOCK_IRQ_EN_BIT                6
`define VDIM_FIELD_RATE_CHANGE_IRQ_EN_BIT      5
`define VDIM_STRIPE_BURST_T3_IRQ_EN_BIT        3
`define VDIM_STRIPE_BURST_ANY_IRQ_EN_BIT       2
`define VDIM_COPY_PROTECT_IRQ_EN_BIT           1
`define VDIM_CAPTURE_READY_IRQ_EN_BIT          0

`endif

// [vdim_pkg.sv]
package vdim_pkg;

  // State of the mask block
  typedef struct packed {
    logic [7:0] mask_one;
    logic [7:0] mask_two;
    logic [7:0] mask_three;
    logic [7:0] rd_data;
  } vdim_top_s;

  // State of one flag group watcher
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] pending;
    logic       primed;
  } vdim_watch_s;

endpackage

// [vdim_watch.sv]
`timescale 1ns/1ps
`include "vdim_defines.svh"

module vdim_watch (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Flag group
  input  wire logic [7:0] flags,
  input  wire logic [7:0] enable,
  input  wire logic       clear,
  // Result
  output logic      [7:0] pending
);

  vdim_pkg::vdim_watch_s st_reg;
  vdim_pkg::vdim_watch_s st_next;
  logic [7:0]            change;

  // Prev is not trusted until one sample has been taken after reset
  assign change  = st_reg.primed ? (flags ^ st_reg.prev) : 8'h00;
  assign pending = st_reg.pending;

  always_comb begin
    st_next        = st_reg;
    st_next.prev   = flags;
    st_next.primed = 1'b1;
    // Set beats a clear arriving in the same cycle
    st_next.pending = (change & enable) |
                      (st_reg.pending & {8{~clear}});
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg.prev    <= `VDIM_RESET_FLAGS;
      st_reg.pending <= `VDIM_RESET_FLAGS;
      st_reg.primed  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  set_wins_clear_a: assert property (
    (|(change & enable)) |=> (|st_reg.pending))
    else $error("enabled flag change not recorded");

  clear_drops_a: assert property (
    (clear && !(|(change & enable))) |=> (st_reg.pending == 8'h00))
    else $error("pending bits survived a clear");

endmodule

// [vdim_host.sv]
`timescale 1ns/1ps

module vdim_host (
  // Clock
  input  wire logic       clk,
  // Subaddress register port
  output logic      [7:0] sub_addr,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  output logic            rd_stb,
  input  wire logic [7:0] rd_data
);
  initial begin
    sub_addr = 8'h00;
    wr_stb   = 1'b0;
    wr_data  = 8'h00;
    rd_stb   = 1'b0;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // Address and data are inverted once released, so nothing can
  // lean on a stale value left on the port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sub_addr <= a;
    wr_data  <= d;
    wr_stb   <= 1'b1;
    @(posedge clk);
    wr_stb   <= 1'b0;
    sub_addr <= ~a;
    wr_data  <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sub_addr <= a;
    rd_stb   <= 1'b1;
    @(posedge clk);
    rd_stb   <= 1'b0;
    sub_addr <= ~a;
    #1;
    d = rd_data;
  endtask

  // Write, then read the same subaddress on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw,
                       output logic [7:0] dr);
    @(posedge clk);
    sub_addr <= a;
    wr_data  <= dw;
    wr_stb   <= 1'b1;
    @(posedge clk);
    wr_stb   <= 1'b0;
    wr_data  <= ~dw;
    rd_stb   <= 1'b1;
    @(posedge clk);
    rd_stb   <= 1'b0;
    sub_addr <= ~a;
    #1;
    dr = rd_data;
  endtask
endmodule

// [tb_video_decoder_interrupt_mask.sv]
`timescale 1ns/1ps
`include "vdim_defines.svh"

`define CHK(nm, exp, got) \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end

module tb_video_decoder_interrupt_mask;
  logic       clk;
  logic       sys_rst;
  logic [7:0] sub_addr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       rd_stb;
  logic [7:0] rd_data;
  logic       irq;
  logic [7:0] flg [4];
  logic [7:0] gaddr [4];
  logic [7:0] d;
  int         n_errors;
  int         n_tests;
  int         cycles;

  vdim_mask vdim_mask_inst (
    .CLK      (clk),
    .SYS_RST  (sys_rst),
    .SUB_ADDR (sub_addr),
    .WR_STB   (wr_stb),
    .WR_DATA  (wr_data),
    .RD_STB   (rd_stb),
    .RD_DATA  (rd_data),
    .FLAGS_60 (flg[0]),
    .FLAGS_8F (flg[1]),
    .FLAGS_1E (flg[2]),
    .FLAGS_1F (flg[3]),
    .IRQ      (irq)
  );

  vdim_host vdim_host_inst (
    .clk      (clk),
    .sub_addr (sub_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data)
  );

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // About 430 cycles are needed; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    vdim_host_inst.rd(a, d);
    `CHK("rd_data", e, d)
  endtask

  // Flag change lands one edge later; three edges cover the answer
  task automatic flip(input int g, input int b);
    @(posedge clk);
    flg[g][b] <= ~flg[g][b];
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Neighbours enabled must not pass this flag; a change seen while
  // masked must not surface later; both edge directions must raise
  task automatic run_event(input int g, input int b, input logic [7:0] ma,
                           input logic [7:0] mv, input int mb);
    logic [7:0] bv;
    bv = 8'h01 << mb;
    vdim_host_inst.wr(ma, mv & ~bv);
    flip(g, b);
    `CHK("irq neighbour", 1'b0, irq)
    vdim_host_inst.wr(ma, bv);
    `CHK("irq masked change", 1'b0, irq)
    flip(g, b);
    `CHK("irq raised", 1'b1, irq)
    vdim_host_inst.wr(ma, 8'h00);
    `CHK("irq hidden", 1'b0, irq)
    vdim_host_inst.wr(ma, bv);
    `CHK("irq shown", 1'b1, irq)
    rd_chk(gaddr[g], 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    flip(g, b);
    `CHK("irq other edge", 1'b1, irq)
    rd_chk(gaddr[g], 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    vdim_host_inst.wr(ma, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst  = 1'b1;
    n_errors = 0;
    n_tests  = 0;
    cycles   = 0;
    for (int i = 0; i < 4; i++) begin
      flg[i] = 8'h00;
    end
    gaddr[0] = `VDIM_ADDR_FLAGS_60;
    gaddr[1] = `VDIM_ADDR_FLAGS_8F;
    gaddr[2] = `VDIM_ADDR_FLAGS_1E;
    gaddr[3] = `VDIM_ADDR_FLAGS_1F;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("irq after reset", 1'b0, irq)
    rd_chk(`VDIM_ADDR_MASK_ONE, 8'h00);
    rd_chk(`VDIM_ADDR_MASK_TWO, 8'h00);
    rd_chk(`VDIM_ADDR_MASK_THREE, 8'h00);
    vdim_host_inst.wr_rd(`VDIM_ADDR_MASK_ONE, 8'hE6, d);
    `CHK("rd_data back to back", 8'h04, d)
    vdim_host_inst.wr(`VDIM_ADDR_MASK_ONE, 8'hFF);
    vdim_host_inst.wr(`VDIM_ADDR_MASK_TWO, 8'hFF);
    vdim_host_inst.wr(`VDIM_ADDR_MASK_THREE, 8'hFF);
    vdim_host_inst.wr(8'h2C, 8'hFF);
    rd_chk(`VDIM_ADDR_MASK_ONE, 8'h1D);
    rd_chk(`VDIM_ADDR_MASK_TWO, 8'h43);
    rd_chk(`VDIM_ADDR_MASK_THREE, 8'hEF);
    rd_chk(8'h2C, 8'h00);
    // Reset in mid-run must drop the masks again
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("irq after second reset", 1'b0, irq)
    rd_chk(`VDIM_ADDR_MASK_ONE, 8'h00);
    rd_chk(`VDIM_ADDR_MASK_TWO, 8'h00);
    rd_chk(`VDIM_ADDR_MASK_THREE, 8'h00);
    run_event(0, 4, 8'h2D, 8'h1D, 4);
    run_event(0, 3, 8'h2D, 8'h1D, 3);
    run_event(0, 2, 8'h2D, 8'h1D, 2);
    run_event(1, 2, 8'h2D, 8'h1D, 0);
    run_event(2, 6, 8'h2E, 8'h43, 6);
    run_event(2, 1, 8'h2E, 8'h43, 1);
    run_event(2, 0, 8'h2E, 8'h43, 0);
    run_event(3, 7, 8'h2F, 8'hEF, 7);
    run_event(3, 6, 8'h2F, 8'hEF, 6);
    run_event(3, 5, 8'h2F, 8'hEF, 5);
    run_event(3, 3, 8'h2F, 8'hEF, 3);
    run_event(3, 2, 8'h2F, 8'hEF, 2);
    run_event(3, 1, 8'h2F, 8'hEF, 1);
    run_event(3, 0, 8'h2F, 8'hEF, 0);
    // Two groups pending: clearing one must leave the other asserting
    vdim_host_inst.wr(`VDIM_ADDR_MASK_ONE, 8'h01);
    vdim_host_inst.wr(`VDIM_ADDR_MASK_THREE, 8'h01);
    flip(1, 2);
    flip(3, 0);
    rd_chk(`VDIM_ADDR_FLAGS_8F, 8'h00);
    `CHK("irq or of groups", 1'b1, irq)
    rd_chk(`VDIM_ADDR_FLAGS_1F, 8'h00);
    `CHK("irq all cleared", 1'b0, irq)
    final_report();
  end
endmodule
